// file: rtl/tag_pkg.sv
// timed write unlock guard: addresses, key values, field positions, reset values and timing counts
// assumes an 8-bit special function register space reached by one-cycle strobes
package tag_pkg;

    // register addresses in the special function space
    localparam logic [7:0] KEY_ADDR = 8'hc7;
    localparam logic [7:0] STATUS_ADDR = 8'hc6;
    localparam logic [7:0] CHIP_CFG_ADDR = 8'h9f;
    localparam logic [7:0] FLASH_TRIG_ADDR = 8'ha4;
    localparam logic [7:0] PWR_MON_ADDR = 8'hac;
    localparam logic [7:0] WDOG_ADDR = 8'haa;

    // guarded set, index 0 to 3
    localparam int PROT_COUNT = 4;
    localparam logic [3:0][7:0] PROT_ADDRS = {WDOG_ADDR, PWR_MON_ADDR, FLASH_TRIG_ADDR, CHIP_CFG_ADDR};

    // key values
    localparam logic [7:0] KEY_FIRST = 8'haa;
    localparam logic [7:0] KEY_SECOND = 8'h55;

    // reset values
    localparam logic [7:0] KEY_RESET = 8'h00;
    localparam logic [7:0] PROT_RESET = 8'h00;

    // status register fields
    localparam int STAT_OPEN_BIT = 0;
    localparam int STAT_ARMED_BIT = 1;
    localparam int STAT_REJECT_BIT = 2;

    // timing in machine cycles, and clocks per machine cycle
    localparam int UNLOCK_SPAN_MC = 3;
    localparam int MCYCLE_CLKS = 4;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } tag_sfr_req_t;

    typedef struct packed {
        logic [7:0] watchdog_ctrl;
        logic [7:0] power_monitor_ctrl;
        logic [7:0] flash_program_trigger;
        logic [7:0] chip_config_reg;
    } tag_prot_regs_t;

    typedef enum logic [1:0] {
        TAG_IDLE,
        TAG_ARMED,
        TAG_OPEN
    } tag_state_t;

endpackage

// file: rtl/tag_mcycle_timer.sv
// machine-cycle span timer: counts a fixed number of machine cycles after each start pulse
// assumes start is a one-cycle pulse from logic on the same clock
`timescale 1ns/1ps

module tag_mcycle_timer #(
    parameter int MC_CLKS = tag_pkg::MCYCLE_CLKS,
    parameter int SPAN_MC = tag_pkg::UNLOCK_SPAN_MC
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // control
    input wire logic start,
    // status
    output logic active,
    output logic mc_tick
);

    localparam int CW = (MC_CLKS > 1) ? $clog2(MC_CLKS) : 1;
    localparam int MW = $clog2(SPAN_MC + 1);
    localparam logic [CW-1:0] CLK_LAST = CW'(MC_CLKS - 1);
    localparam logic [MW-1:0] SPAN_LOAD = MW'(SPAN_MC);

    logic [CW-1:0] clk_cnt_reg;
    logic [MW-1:0] mc_left_reg;

    // divider restarts with each start so the span is exact, not off by a partial machine cycle
    assign mc_tick = (clk_cnt_reg == CLK_LAST);
    assign active = (mc_left_reg != '0);

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            clk_cnt_reg <= '0;
            mc_left_reg <= '0;
        end
        else if (start)
        begin
            clk_cnt_reg <= '0;
            mc_left_reg <= SPAN_LOAD;
        end
        else
        begin
            clk_cnt_reg <= mc_tick ? '0 : clk_cnt_reg + CW'(1);
            if (mc_tick && active)
            begin
                mc_left_reg <= mc_left_reg - MW'(1);
            end
        end
    end

endmodule // tag_mcycle_timer

// file: rtl/tag_guard.sv
// timed write unlock guard: access key register, sequence tracking, guarded register storage
// assumes the processor core drives one-cycle read and write strobes on the same clock
`timescale 1ns/1ps

// Operation
// - Unlocking needs a write of AAH to the key register followed by a write of 55H to it, in that order only.
// - A write of AAH to the key register outside an open window starts a counter that watches for the 55H write.
// - The window opens only when the 55H write lands within three machine cycles of the AAH write.
// - A 55H write later than three machine cycles leaves the window closed so later guarded writes fail.
// - An opened window stays active three machine cycles and then closes by itself.
// - A guarded write takes effect only while the window is active, otherwise it is dropped.
// - Several guarded writes may succeed in one window and any after it closes are rejected.
// - Guarded registers read back at any time with no unlock needed.
// - The guarded set is the chip configuration, flash trigger, power monitor and watchdog registers at 9FH, A4H, ACH, AAH.
// - The key register is eight bits at C7H, resets to zero and gates access to the guarded set.
module tag_guard #(
    parameter int MC_CLKS = tag_pkg::MCYCLE_CLKS
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // register port from the core
    input wire tag_pkg::tag_sfr_req_t sfr_req,
    output logic [7:0] sfr_rdata,
    // guarded register contents
    output tag_pkg::tag_prot_regs_t prot_regs,
    // one-cycle pulses per guarded register
    output logic [tag_pkg::PROT_COUNT-1:0] prot_wr_done,
    output logic [tag_pkg::PROT_COUNT-1:0] prot_wr_rejected,
    // guard state
    output logic window_open,
    output logic seq_armed
);

    tag_pkg::tag_state_t state_reg;
    tag_pkg::tag_state_t state_next;
    logic [7:0] key_reg;
    logic reject_reg;
    logic reject_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic [7:0] prot_reg [tag_pkg::PROT_COUNT];
    logic [tag_pkg::PROT_COUNT-1:0] prot_hit;
    logic [tag_pkg::PROT_COUNT-1:0] prot_accept;
    logic [tag_pkg::PROT_COUNT-1:0] done_reg;
    logic [tag_pkg::PROT_COUNT-1:0] rej_reg;
    logic timer_start;
    logic timer_active;
    logic [7:0] status_val;
    logic [7:0] prot_rd_val;

    // address decode
    wire key_wr = sfr_req.wr && (sfr_req.addr == tag_pkg::KEY_ADDR);
    wire status_wr = sfr_req.wr && (sfr_req.addr == tag_pkg::STATUS_ADDR);
    wire key_first = key_wr && (sfr_req.wdata == tag_pkg::KEY_FIRST);
    wire key_second = key_wr && (sfr_req.wdata == tag_pkg::KEY_SECOND);
    wire in_open = (state_reg == tag_pkg::TAG_OPEN) && timer_active;
    wire in_armed = (state_reg == tag_pkg::TAG_ARMED) && timer_active;
    wire unlock_ok = in_armed && key_second;
    wire any_reject = |(prot_hit & ~prot_accept);
    wire reject_clr = status_wr && sfr_req.wdata[tag_pkg::STAT_REJECT_BIT];

    // one timer serves both the arming wait and the open window, as they never overlap
    assign timer_start = (key_first && !in_open) || unlock_ok;

    tag_mcycle_timer #(
        .MC_CLKS(MC_CLKS),
        .SPAN_MC(tag_pkg::UNLOCK_SPAN_MC)
    ) u_timer (
        .clock(clock),
        .rst(rst),
        .start(timer_start),
        .active(timer_active),
        .mc_tick()
    );

    // sequence state
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            tag_pkg::TAG_IDLE:
            begin
                if (key_first)
                begin
                    state_next = tag_pkg::TAG_ARMED;
                end
            end
            tag_pkg::TAG_ARMED:
            begin
                if (unlock_ok)
                begin
                    state_next = tag_pkg::TAG_OPEN;
                end
                else if (key_first)
                begin
                    state_next = tag_pkg::TAG_ARMED;
                end
                else if (key_wr || !timer_active)
                begin
                    state_next = tag_pkg::TAG_IDLE;
                end
            end
            tag_pkg::TAG_OPEN:
            begin
                // a first key in the cycle the window has just closed must still arm
                if (!timer_active && key_first)
                begin
                    state_next = tag_pkg::TAG_ARMED;
                end
                else if (!timer_active)
                begin
                    state_next = tag_pkg::TAG_IDLE;
                end
            end
            default:
            begin
                state_next = tag_pkg::TAG_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            state_reg <= tag_pkg::TAG_IDLE;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // key register holds the last value written; it reads back like any register
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            key_reg <= tag_pkg::KEY_RESET;
        end
        else if (key_wr)
        begin
            key_reg <= sfr_req.wdata;
        end
    end

    // guarded registers, one per entry
    genvar gi;
    generate
        for (gi = 0; gi < tag_pkg::PROT_COUNT; gi++)
        begin : g_prot
            assign prot_hit[gi] = sfr_req.wr && (sfr_req.addr == tag_pkg::PROT_ADDRS[gi]);
            assign prot_accept[gi] = prot_hit[gi] && in_open;

            always_ff @(posedge clock or posedge rst)
            begin
                if (rst)
                begin
                    prot_reg[gi] <= tag_pkg::PROT_RESET;
                end
                else if (prot_accept[gi])
                begin
                    prot_reg[gi] <= sfr_req.wdata;
                end
            end
        end
    endgenerate

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            done_reg <= '0;
            rej_reg <= '0;
        end
        else
        begin
            done_reg <= prot_accept;
            rej_reg <= prot_hit & ~prot_accept;
        end
    end

    // sticky reject flag: a new reject in the clearing cycle keeps it set
    assign reject_next = any_reject || (reject_reg && !reject_clr);

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            reject_reg <= 1'b0;
        end
        else
        begin
            reject_reg <= reject_next;
        end
    end

    // read path: never guarded, answered one cycle after the strobe
    assign status_val = {5'h00, reject_reg, in_armed, in_open};

    always_comb
    begin
        prot_rd_val = 8'h00;
        for (int i = 0; i < tag_pkg::PROT_COUNT; i++)
        begin
            if (sfr_req.addr == tag_pkg::PROT_ADDRS[i])
            begin
                prot_rd_val = prot_reg[i];
            end
        end
    end

    always_comb
    begin
        rdata_next = 8'h00;
        if (sfr_req.rd)
        begin
            if (sfr_req.addr == tag_pkg::KEY_ADDR)
            begin
                rdata_next = key_reg;
            end
            else if (sfr_req.addr == tag_pkg::STATUS_ADDR)
            begin
                rdata_next = status_val;
            end
            else
            begin
                rdata_next = prot_rd_val;
            end
        end
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            rdata_reg <= 8'h00;
        end
        else
        begin
            rdata_reg <= rdata_next;
        end
    end

    // outputs
    assign sfr_rdata = rdata_reg;
    assign prot_regs.chip_config_reg = prot_reg[0];
    assign prot_regs.flash_program_trigger = prot_reg[1];
    assign prot_regs.power_monitor_ctrl = prot_reg[2];
    assign prot_regs.watchdog_ctrl = prot_reg[3];
    assign prot_wr_done = done_reg;
    assign prot_wr_rejected = rej_reg;
    assign window_open = in_open;
    assign seq_armed = in_armed;

endmodule // tag_guard

// file: verif/tag_core_model.sv
// core model: issues one-cycle register strobes to the guard
// assumes the bench calls its tasks from a rising clock edge
`timescale 1ns/1ps

module tag_core_model (
    // clock
    input wire logic clock,
    // register port
    output tag_pkg::tag_sfr_req_t sfr_req,
    input wire logic [7:0] sfr_rdata
);
    int t = 0;

    initial sfr_req = '0;

    task automatic step(input tag_pkg::tag_sfr_req_t r);
        sfr_req <= r;
        @(posedge clock);
        t++;
    endtask

    // strobes go back to back, as if interrupts were held off around the keys
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        step({a, d, 1'b1, 1'b0});
    endtask

    task automatic idle(input int n);
        repeat (n) step('0);
    endtask

    // data are taken before the edge updates land, the one cycle they stand
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        step({a, 8'h00, 1'b0, 1'b1});
        step('0);
        d = sfr_rdata;
    endtask
endmodule // tag_core_model

// file: verif/tag_guard_checker.sv
// assertions on the guard ports
// assumes one clock domain, reset asynchronous and active high
`timescale 1ns/1ps

module tag_guard_checker #(
    parameter int MC_CLKS = 4
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // register port
    input wire tag_pkg::tag_sfr_req_t sfr_req,
    input wire logic [7:0] sfr_rdata,
    // guarded contents and state
    input wire tag_pkg::tag_prot_regs_t prot_regs,
    input wire logic [tag_pkg::PROT_COUNT-1:0] prot_wr_done,
    input wire logic [tag_pkg::PROT_COUNT-1:0] prot_wr_rejected,
    input wire logic window_open,
    input wire logic seq_armed
);
    localparam int SPAN = tag_pkg::UNLOCK_SPAN_MC * MC_CLKS;
    logic [tag_pkg::PROT_COUNT-1:0] prot_hit;
    logic [15:0] open_cnt;
    logic [15:0] wait_cnt;
    wire key_wr = sfr_req.wr && sfr_req.addr == tag_pkg::KEY_ADDR;
    wire cfg_wr = sfr_req.wr && sfr_req.addr == tag_pkg::CHIP_CFG_ADDR;
    wire key_aa = key_wr && sfr_req.wdata == tag_pkg::KEY_FIRST;

    genvar gi;
    for (gi = 0; gi < tag_pkg::PROT_COUNT; gi++)
    begin : g_hit
        assign prot_hit[gi] = sfr_req.wr && sfr_req.addr == tag_pkg::PROT_ADDRS[gi];
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    sequence s_key(logic [7:0] v);
        key_wr && sfr_req.wdata == v;
    endsequence

    // a fresh first key restarts the wait count
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            open_cnt <= '0;
            wait_cnt <= '0;
        end
        else
        begin
            open_cnt <= window_open ? open_cnt + 16'h0001 : '0;
            wait_cnt <= (seq_armed && !key_aa) ? wait_cnt + 16'h0001 : '0;
        end
    end

    AST_ARM: assert property (s_key(tag_pkg::KEY_FIRST) ##0 !window_open |=> seq_armed)
        else $error("first key did not arm");
    AST_OPEN: assert property (s_key(tag_pkg::KEY_SECOND) ##0 seq_armed |=> window_open)
        else $error("second key did not open");
    AST_NO_SEQ: assert property (s_key(tag_pkg::KEY_SECOND) ##0 !(seq_armed || window_open) |=> !window_open)
        else $error("window opened without first key");
    AST_ABANDON: assert property (key_wr && seq_armed && sfr_req.wdata != tag_pkg::KEY_SECOND && !key_aa
        |=> !seq_armed && !window_open)
        else $error("wrong key did not abandon");
    AST_ARM_SPAN: assert property (seq_armed |-> wait_cnt < SPAN)
        else $error("armed too long");
    AST_OPEN_SPAN: assert property (window_open |-> open_cnt < SPAN)
        else $error("window open too long");
    AST_CLOSE: assert property ($fell(window_open) |-> open_cnt == SPAN)
        else $error("window closed early");
    AST_ACCEPT: assert property (cfg_wr && window_open
        |=> prot_wr_done[0] && prot_regs.chip_config_reg == $past(sfr_req.wdata))
        else $error("open write not taken");
    AST_DROP: assert property (cfg_wr && !window_open
        |=> prot_wr_rejected[0] && $stable(prot_regs.chip_config_reg))
        else $error("closed write not dropped");
    AST_READ: assert property (sfr_req.rd && sfr_req.addr == tag_pkg::WDOG_ADDR
        |=> sfr_rdata == $past(prot_regs.watchdog_ctrl))
        else $error("read data wrong");
    AST_DONE_MAP: assert property (window_open |=> prot_wr_done == $past(prot_hit))
        else $error("done pulses do not match open writes");
    AST_REJ_MAP: assert property (!window_open |=> prot_wr_rejected == $past(prot_hit))
        else $error("reject pulses do not match closed writes");
endmodule // tag_guard_checker

bind tag_guard tag_guard_checker #(.MC_CLKS(MC_CLKS)) tag_guard_checker_inst (
    .clock(clock),
    .rst(rst),
    .sfr_req(sfr_req),
    .sfr_rdata(sfr_rdata),
    .prot_regs(prot_regs),
    .prot_wr_done(prot_wr_done),
    .prot_wr_rejected(prot_wr_rejected),
    .window_open(window_open),
    .seq_armed(seq_armed)
);

// file: verif/tag_guard_test.sv
// bench for the guard with an integer model of the unlock timing
// assumes one clock per machine cycle, so every span is three clocks
`timescale 1ns/1ps

module tag_guard_test;
    localparam int SPAN = tag_pkg::UNLOCK_SPAN_MC;
    logic clock = 1'b0;
    logic rst = 1'b1;
    tag_pkg::tag_sfr_req_t sfr_req;
    tag_pkg::tag_prot_regs_t prot_regs;
    logic [7:0] sfr_rdata;
    logic [7:0] rv;
    logic window_open;
    logic seq_armed;
    int mismatches = 0;
    int checked = 0;
    int cycles = 0;
    int seed = 17588;
    int arm_t = -100;
    int open_t = -100;
    bit armed = 0;
    bit rej = 0;
    int mdl[4] = '{0, 0, 0, 0};

    always #5 clock = ~clock;

    tag_guard #(.MC_CLKS(1)) tag_guard_inst (.clock(clock), .rst(rst), .sfr_req(sfr_req),
        .sfr_rdata(sfr_rdata), .prot_regs(prot_regs), .prot_wr_done(), .prot_wr_rejected(),
        .window_open(window_open), .seq_armed(seq_armed));
    tag_core_model tag_core_model_inst (.clock(clock), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata));

    task automatic put(input logic [7:0] a, input logic [7:0] d);
        int now;
        bit op;
        tag_core_model_inst.wr(a, d);
        now = tag_core_model_inst.t;
        op = now - open_t <= SPAN;
        if (now - arm_t > SPAN) armed = 0;
        // key writes are ignored while the window is open
        if (a == tag_pkg::KEY_ADDR && !op)
        begin
            if (d == tag_pkg::KEY_SECOND && armed) open_t = now;
            armed = d == tag_pkg::KEY_FIRST;
            if (armed) arm_t = now;
        end
        for (int i = 0; i < 4; i++)
            if (a == tag_pkg::PROT_ADDRS[i])
            begin
                if (op) mdl[i] = d;
                else rej = 1;
            end
        if (a == tag_pkg::STATUS_ADDR && d[tag_pkg::STAT_REJECT_BIT]) rej = 0;
    endtask

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // status reflects the state at the read strobe's edge
    task automatic stat(input string what);
        int now;
        logic [7:0] e;
        tag_core_model_inst.rd(tag_pkg::STATUS_ADDR, rv);
        now = tag_core_model_inst.t - 1;
        e = 8'h00;
        e[tag_pkg::STAT_REJECT_BIT] = rej;
        e[tag_pkg::STAT_ARMED_BIT] = armed && now - arm_t >= 1 && now - arm_t <= SPAN;
        e[tag_pkg::STAT_OPEN_BIT] = now - open_t >= 1 && now - open_t <= SPAN;
        chk(what, e, rv);
    endtask

    task automatic scan();
        for (int i = 0; i < 4; i++)
        begin
            tag_core_model_inst.rd(tag_pkg::PROT_ADDRS[i], rv);
            chk("readback", mdl[i][7:0], rv);
            chk("contents", mdl[i][7:0], prot_regs[8*i +: 8]);
        end
    endtask

    task automatic wrap_up();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            mismatches++;
            wrap_up();
        end
    end

    initial
    begin
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        tag_core_model_inst.idle(1);
        scan();
        tag_core_model_inst.rd(tag_pkg::KEY_ADDR, rv);
        chk("key reset", tag_pkg::KEY_RESET, rv);
        stat("status reset");
        tag_core_model_inst.rd(8'h10, rv);
        chk("unmapped", 8'h00, rv);
        // every key gap and write gap up to one past the span; each round with a key gap within the span unlocks anew
        for (int g = 1; g <= SPAN + 1; g++)
            for (int w = 1; w <= SPAN + 1; w++)
            begin
                put(tag_pkg::KEY_ADDR, tag_pkg::KEY_FIRST);
                tag_core_model_inst.idle(g - 1);
                put(tag_pkg::KEY_ADDR, tag_pkg::KEY_SECOND);
                tag_core_model_inst.idle(w - 1);
                put(tag_pkg::PROT_ADDRS[(g + w) % 4], 8'($random(seed)));
                put(tag_pkg::PROT_ADDRS[(g + w + 1) % 4], 8'($random(seed)));
                tag_core_model_inst.idle(SPAN);
                scan();
            end
        put(tag_pkg::KEY_ADDR, tag_pkg::KEY_FIRST);
        put(tag_pkg::KEY_ADDR, 8'h33);
        put(tag_pkg::KEY_ADDR, tag_pkg::KEY_SECOND);
        put(tag_pkg::CHIP_CFG_ADDR, 8'h5a);
        put(tag_pkg::KEY_ADDR, tag_pkg::KEY_FIRST);
        tag_core_model_inst.idle(2);
        put(tag_pkg::KEY_ADDR, tag_pkg::KEY_FIRST);
        tag_core_model_inst.idle(2);
        put(tag_pkg::KEY_ADDR, tag_pkg::KEY_SECOND);
        put(tag_pkg::WDOG_ADDR, 8'hc3);
        tag_core_model_inst.idle(SPAN);
        scan();
        // a first key in the closing cycle of a window arms again
        put(tag_pkg::KEY_ADDR, tag_pkg::KEY_FIRST);
        put(tag_pkg::KEY_ADDR, tag_pkg::KEY_SECOND);
        tag_core_model_inst.idle(SPAN);
        put(tag_pkg::KEY_ADDR, tag_pkg::KEY_FIRST);
        stat("status armed");
        put(tag_pkg::KEY_ADDR, tag_pkg::KEY_SECOND);
        stat("status open");
        put(tag_pkg::PWR_MON_ADDR, 8'($random(seed)));
        scan();
        stat("status reject");
        put(tag_pkg::STATUS_ADDR, 8'(1 << tag_pkg::STAT_REJECT_BIT));
        stat("status clear");
        wrap_up();
    end
endmodule // tag_guard_test
